//--- rtl/tcc_defs.svh
/*
 * constants of the compensation control block: register offsets, field
 * positions, power-up values and timing.
 * assumes it is included by bare name wherever a constant is needed.
 */
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register offsets
`define TCC_ADDR_INIT_TRIM 8'h0B
`define TCC_ADDR_COLD_CURV 8'h0C
`define TCC_ADDR_TRIM_CTRL 8'h0D

// fields of compensation_trim_control
`define TCC_TSE_BIT 7
`define TCC_BMODE_HI 6
`define TCC_BMODE_LO 5
`define TCC_TRIM_HI 4
`define TCC_BMODE_OFF 2'h0

// values read and held after reset
`define TCC_BYTE_ZERO 8'h00
`define TCC_TRIM_ZERO 5'h00
`define TCC_BMODE_ZERO 2'h0

// timing: correction period and clock rate
`define TCC_CORR_PERIOD_S 60
`define TCC_CLK_HZ 20000000
`define TCC_CNT_W 31
`define TCC_CONV_CYCLES 32

`endif

//--- rtl/tcc_pkg.sv
/*
 * types of the compensation control block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package tcc_pkg;
	typedef enum logic [1:0] {TCC_SEL_NONE, TCC_SEL_INIT, TCC_SEL_COLD, TCC_SEL_CTRL} tcc_sel_type;
	typedef enum logic [1:0] {TCC_CONV_IDLE, TCC_CONV_WAIT, TCC_CONV_LOAD} tcc_conv_state_type;
endpackage

//--- rtl/tcc_sync2.sv
/*
 * two flip-flop synchroniser, one chain per bit.
 * assumes each input bit is a slow level from outside the clock domain.
 */
`timescale 1ns/1ns
module tcc_sync2 #(
	parameter int W = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic stage1;
			// first stage is read only by the second
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					stage1 <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					stage1 <= async_in[i];
					sync_out[i] <= stage1;
				end
			end
		end
	endgenerate
endmodule // tcc_sync2

//--- rtl/tcc_convert.sv
/*
 * one temperature conversion: waits out the conversion time, samples the
 * temperature and reloads the trim results on the first one after reset, then only when it changed.
 * assumes temperature and calculated trims come from same-clock logic.
 */
`timescale 1ns/1ns
`include "tcc_defs.svh"
module tcc_convert import tcc_pkg::*; #(
	parameter int TW = 10,
	parameter int AW = 6,
	parameter int DW = 3,
	parameter int CONV_CYCLES = `TCC_CONV_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [TW-1:0] temp_code,
	input wire logic [AW-1:0] calc_analog,
	input wire logic [DW-1:0] calc_digital,
	output logic busy,
	output logic reload,
	output logic [AW-1:0] analog_trim_result,
	output logic [DW-1:0] digital_trim_result
);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	tcc_conv_state_type state, next_state;
	logic [CW-1:0] wait_cnt, next_wait_cnt;
	logic [TW-1:0] last_temp, next_last_temp;
	logic have_last, next_have_last;
	logic next_reload;
	logic [AW-1:0] next_analog;
	logic [DW-1:0] next_digital;
	logic changed;

	// first conversion after reset always loads, later ones only on change
	assign changed = !have_last || (temp_code != last_temp);
	assign busy = (state != TCC_CONV_IDLE);

	// conversion sequencing
	always_comb begin
		next_state = state;
		next_wait_cnt = wait_cnt;
		next_last_temp = last_temp;
		next_have_last = have_last;
		next_reload = 1'b0;
		next_analog = analog_trim_result;
		next_digital = digital_trim_result;
		case (state)
			TCC_CONV_IDLE: begin
				if (start) begin
					next_state = TCC_CONV_WAIT;
					next_wait_cnt = CW'(CONV_CYCLES - 1);
				end
			end
			TCC_CONV_WAIT: begin
				if (wait_cnt == '0) begin
					next_state = TCC_CONV_LOAD;
				end else begin
					next_wait_cnt = wait_cnt - 1'b1;
				end
			end
			TCC_CONV_LOAD: begin
				next_state = TCC_CONV_IDLE;
				if (changed) begin
					next_analog = calc_analog;
					next_digital = calc_digital;
					next_reload = 1'b1;
					next_last_temp = temp_code;
					next_have_last = 1'b1;
				end
			end
			default: next_state = TCC_CONV_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= TCC_CONV_IDLE;
			wait_cnt <= '0;
			last_temp <= '0;
			have_last <= 1'b0;
			reload <= 1'b0;
			analog_trim_result <= '0;
			digital_trim_result <= '0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
			last_temp <= next_last_temp;
			have_last <= next_have_last;
			reload <= next_reload;
			analog_trim_result <= next_analog;
			digital_trim_result <= next_digital;
		end
	end

	AST_RELOAD_ONLY_ON_CHANGE: assert property (@(posedge clock) disable iff (!rst_n)
		(state == TCC_CONV_LOAD && have_last && temp_code == last_temp) |=> !reload && $stable(analog_trim_result))
		else $error("trim results reloaded without a temperature change");
endmodule // tcc_convert

//--- rtl/tcc_ctrl.sv
/*
 * temperature compensation control: the three compensation registers,
 * supply switchover, periodic correction timer and conversion kick-off.
 * assumes the serial interface delivers decoded one-cycle register
 * strobes on this clock, and supply comparators arrive as async levels.
 * limitation: on backup the stride counts whole periods, so the first
 * backup correction may come up to one stride after the switchover.
 */
`timescale 1ns/1ns
`include "tcc_defs.svh"

module tcc_ctrl import tcc_pkg::*; #(
	parameter int unsigned CORR_CYCLES = `TCC_CORR_PERIOD_S * `TCC_CLK_HZ,
	parameter int CONV_CYCLES = `TCC_CONV_CYCLES,
	parameter int TW = 10,
	parameter int AW = 6,
	parameter int DW = 3
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic main_below_thresh,
	input wire logic backup_above_2v7,
	input wire logic [4:0] factory_compensation_trim_control_trim,
	input wire logic [7:0] factory_initial_trim,
	input wire logic [7:0] factory_cold_curvature,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [TW-1:0] temp_code,
	input wire logic [AW-1:0] calc_analog,
	input wire logic [DW-1:0] calc_digital,
	output logic on_backup,
	output logic serial_enable,
	output logic sram_keep_powered,
	output logic osc_enable,
	output logic comp_allowed,
	output logic conv_busy,
	output logic trim_reload,
	output logic [AW-1:0] analog_trim_result,
	output logic [DW-1:0] digital_trim_result
);
	logic below_s, bat_ok_s;
	logic loaded, next_loaded;
	logic ctrl_tse, next_ctrl_tse;
	logic [1:0] bmode, next_bmode;
	logic [4:0] compensation_trim_control_trim, next_compensation_trim_control_trim;
	logic [7:0] init_trim, next_init_trim;
	logic [7:0] cold_curv, next_cold_curv;
	logic [7:0] next_rdata;
	logic [`TCC_CNT_W-1:0] cnt, next_cnt;
	logic [1:0] epoch, next_epoch;
	logic [1:0] last_epoch;
	logic pending, next_pending;
	logic next_on_backup;
	logic bus_ok, wr_ctrl, kick, tick, want, conv_start;

	// register select, shared by the write and the read path
	function automatic tcc_sel_type reg_sel(input logic [7:0] addr);
		case (addr)
			`TCC_ADDR_INIT_TRIM: reg_sel = TCC_SEL_INIT;
			`TCC_ADDR_COLD_CURV: reg_sel = TCC_SEL_COLD;
			`TCC_ADDR_TRIM_CTRL: reg_sel = TCC_SEL_CTRL;
			default: reg_sel = TCC_SEL_NONE;
		endcase
	endfunction

	// comparator levels come from the analogue side, so synchronise first
	tcc_sync2 #(.W(2)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in({main_below_thresh, backup_above_2v7}),
		.sync_out({below_s, bat_ok_s})
	);

	// supply selection follows the comparator, no host action needed
	always_comb begin
		next_on_backup = below_s;
	end

	// registered so the serial gate and the stride switch on the same edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			on_backup <= 1'b0;
		end else begin
			on_backup <= next_on_backup;
		end
	end

	// oscillator and SRAM stay up in either supply mode
	assign osc_enable = loaded;
	assign sram_keep_powered = loaded;
	assign serial_enable = !on_backup;
	// accesses before the factory values are in place are dropped too
	assign bus_ok = serial_enable && loaded;
	assign wr_ctrl = bus_ok && reg_wr && (reg_sel(reg_addr) == TCC_SEL_CTRL);

	// register file: factory recall once after reset, then host access
	always_comb begin
		next_loaded = 1'b1;
		next_ctrl_tse = ctrl_tse;
		next_bmode = bmode;
		next_compensation_trim_control_trim = compensation_trim_control_trim;
		next_init_trim = init_trim;
		next_cold_curv = cold_curv;
		next_rdata = reg_rdata;
		if (!loaded) begin
			next_compensation_trim_control_trim = factory_compensation_trim_control_trim;
			next_init_trim = factory_initial_trim;
			next_cold_curv = factory_cold_curvature;
		end
		// only the control bits take the written byte; the read-only registers ignore writes
		if (wr_ctrl) begin
			next_ctrl_tse = reg_wdata[`TCC_TSE_BIT];
			next_bmode = reg_wdata[`TCC_BMODE_HI:`TCC_BMODE_LO];
		end
		// reads answer next cycle and hold; a refused read keeps the old byte
		if (bus_ok && reg_rd) begin
			case (reg_sel(reg_addr))
				TCC_SEL_INIT: next_rdata = init_trim;
				TCC_SEL_COLD: next_rdata = cold_curv;
				TCC_SEL_CTRL: next_rdata = {ctrl_tse, bmode, compensation_trim_control_trim};
				default: next_rdata = `TCC_BYTE_ZERO;
			endcase
		end
	end

	// reset keeps loaded low, which also holds the serial port shut until recall
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			loaded <= 1'b0;
			ctrl_tse <= 1'b0;
			bmode <= `TCC_BMODE_ZERO;
			compensation_trim_control_trim <= `TCC_TRIM_ZERO;
			init_trim <= `TCC_BYTE_ZERO;
			cold_curv <= `TCC_BYTE_ZERO;
			reg_rdata <= `TCC_BYTE_ZERO;
		end else begin
			loaded <= next_loaded;
			ctrl_tse <= next_ctrl_tse;
			bmode <= next_bmode;
			compensation_trim_control_trim <= next_compensation_trim_control_trim;
			init_trim <= next_init_trim;
			cold_curv <= next_cold_curv;
			reg_rdata <= next_rdata;
		end
	end

	// on backup, the mode field picks the stride in periods (off, 1, 2, 4)
	assign comp_allowed = ctrl_tse && (!on_backup || (bat_ok_s && bmode != `TCC_BMODE_OFF));
	assign last_epoch = on_backup ? {bmode[1] & bmode[0], bmode[1]} : 2'h0;
	// on main every period counts; the stride only applies on backup
	assign tick = comp_allowed && (cnt == `TCC_CNT_W'(CORR_CYCLES - 1)) &&
		(!on_backup || epoch == last_epoch);
	// an enabled write restarts the wait so the next correction is a full period later
	assign kick = wr_ctrl && reg_wdata[`TCC_TSE_BIT];
	assign want = kick || tick || pending;
	assign conv_start = want && !conv_busy && (comp_allowed || kick);

	// correction timer and request holding; a request during a conversion waits
	always_comb begin
		next_cnt = cnt;
		next_epoch = epoch;
		// a kick while busy is held even though the old enable may still read low
		next_pending = conv_busy && (kick || (want && ctrl_tse));
		if (!comp_allowed || kick) begin
			next_cnt = '0;
			next_epoch = 2'h0;
		end else if (cnt == `TCC_CNT_W'(CORR_CYCLES - 1)) begin
			next_cnt = '0;
			// an epoch left over from backup must not delay corrections on main
			next_epoch = (epoch == last_epoch || !on_backup) ? 2'h0 : epoch + 2'h1;
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	// timer state; cleared on reset so the first period is a full one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			epoch <= 2'h0;
			pending <= 1'b0;
		end else begin
			cnt <= next_cnt;
			epoch <= next_epoch;
			pending <= next_pending;
		end
	end

	tcc_convert #(.TW(TW), .AW(AW), .DW(DW), .CONV_CYCLES(CONV_CYCLES)) u_conv (
		.clock(clock),
		.rst_n(rst_n),
		.start(conv_start),
		.temp_code(temp_code),
		.calc_analog(calc_analog),
		.calc_digital(calc_digital),
		.busy(conv_busy),
		.reload(trim_reload),
		.analog_trim_result(analog_trim_result),
		.digital_trim_result(digital_trim_result)
	);

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_SWITCH_TO_BACKUP: assert property (below_s |=> on_backup)
		else $error("no switchover after main supply fell");
	AST_BACKUP_IGNORES_WRITE: assert property (on_backup && reg_wr |=> $stable(ctrl_tse) && $stable(bmode))
		else $error("control changed by a write while on backup");
	AST_BACKUP_KEEPS_OSC: assert property (loaded && on_backup |-> osc_enable && !serial_enable)
		else $error("oscillator stopped or serial live on backup");
	AST_SRAM_POWERED: assert property ($rose(on_backup) |-> sram_keep_powered [*3])
		else $error("sram power dropped on backup");
	AST_LOW_BAT_NO_COMP: assert property (on_backup && !bat_ok_s && !kick |-> !conv_start)
		else $error("compensation started on a weak backup supply");
	AST_FACTORY_RECALL: assert property ($rose(loaded) |-> compensation_trim_control_trim == $past(factory_compensation_trim_control_trim))
		else $error("factory trim not recalled at power-up");
	AST_ENABLED_WRITE_CONVERTS: assert property (kick |-> ##[1:4] conv_busy)
		else $error("enabled write did not start a conversion");
	AST_PERIOD_CONVERTS: assert property (tick && !on_backup |-> conv_start || conv_busy)
		else $error("period expired without a correction");
	AST_READ_ONLY: assert property (loaded |=> $stable(init_trim) && $stable(cold_curv))
		else $error("read-only register changed");
	AST_TRIM_LOCKED: assert property (loaded && wr_ctrl |=> $stable(compensation_trim_control_trim))
		else $error("locked trim value changed by a write");
	AST_TSE_OFF_IDLE: assert property (!ctrl_tse && !kick |=> cnt == '0 && !pending)
		else $error("timer ran with sense disabled");
	AST_BMODE_OFF: assert property (on_backup && bmode == `TCC_BMODE_OFF |-> !tick)
		else $error("periodic correction on backup with mode off");

	// further checks on the register paths and the correction timer

	// a write held back by a running conversion must not be lost
	AST_KICK_HELD: assert property (kick && conv_busy |=> pending)
		else $error("enabled write dropped during a conversion");

	// the control write takes bits 7:5 and nothing else
	AST_CTRL_WRITE_TAKES: assert property (wr_ctrl |=> ctrl_tse == $past(reg_wdata[`TCC_TSE_BIT]) &&
		bmode == $past(reg_wdata[`TCC_BMODE_HI:`TCC_BMODE_LO]))
		else $error("control bits not taken from the written byte");

	// reads on backup must leave the last answer on the port
	AST_BACKUP_IGNORES_READ: assert property (on_backup && reg_rd |=> $stable(reg_rdata))
		else $error("read answered while on backup");

	// the weak-battery gate must close compensation, not only the start
	AST_BATTERY_GATE: assert property (on_backup && !bat_ok_s |-> !comp_allowed)
		else $error("compensation allowed on a weak backup supply");

	// the timer must wrap at the period end, never run past it
	AST_TIMER_BOUNDED: assert property (cnt <= `TCC_CNT_W'(CORR_CYCLES - 1))
		else $error("correction timer ran past its period");

	// on main supply every period end is a correction, whatever the epoch
	AST_MAIN_EVERY_PERIOD: assert property (comp_allowed && !on_backup &&
		cnt == `TCC_CNT_W'(CORR_CYCLES - 1) |-> tick)
		else $error("period ended on main supply without a correction");

	// an enabled write restarts the correction wait
	AST_KICK_RESTARTS_TIMER: assert property (kick |=> cnt == '0)
		else $error("enabled write did not restart the timer");

	// reloaded results are the trims offered in the load cycle
	AST_RELOAD_MATCHES: assert property (trim_reload |-> analog_trim_result == $past(calc_analog) &&
		digital_trim_result == $past(calc_digital))
		else $error("reloaded trims differ from the calculated ones");

	// the factory recall happens once, so later writes cannot be undone by it
	AST_LOAD_ONCE: assert property (loaded |=> loaded)
		else $error("factory recall repeated after power-up");

	// the read-only pair starts from the factory values
	AST_FACTORY_READ_ONLY: assert property ($rose(loaded) |-> init_trim == $past(factory_initial_trim) &&
		cold_curv == $past(factory_cold_curvature))
		else $error("read-only registers not recalled at power-up");

	// with sense disabled no conversion begins unless an enabling write arrives
	AST_TSE_OFF_NO_START: assert property (!ctrl_tse && !kick && !conv_busy |=> !conv_busy)
		else $error("conversion started with sense disabled");

	// the serial gate must shut on backup
	AST_BACKUP_NO_BUS: assert property (on_backup |-> !bus_ok)
		else $error("register bus open while on backup");

	// main scenarios, for coverage
	COV_KICK: cover property (kick ##[1:4] conv_busy);
	COV_TICK: cover property (tick && !on_backup);
	COV_BACKUP: cover property ($rose(on_backup));
	COV_RELOAD: cover property (trim_reload);
	COV_BACKUP_TICK: cover property (tick && on_backup);
endmodule // tcc_ctrl

//--- sim/tcc_host.sv
/*
 * host side model: issues one-cycle register strobes as a bus master would.
 * assumes strobes are launched on the falling edge and the block samples
 * them on the rising edge of the same clock.
 */
`timescale 1ns/1ns
module tcc_host (
	input wire logic clock,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// released lines show the inverse so stale values cannot pass for fresh ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask

	// enable sequence: keep the locked low bits as read, replace control bits
	task automatic enable_comp(input logic [2:0] ctl);
		logic [7:0] v;
		rd(8'h0D);
		v = reg_rdata;
		wr(8'h0D, {ctl, v[4:0]});
	endtask

	// slow host: leave gaps between requests
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask
endmodule // tcc_host

//--- sim/tb_tcc_ctrl.sv
/*
 * self-checking bench of the compensation control block with a host model.
 * assumes short correction and conversion counts set by parameter.
 */
`timescale 1ns/1ns
module tb_tcc_ctrl import tcc_pkg::*;;
	localparam int CORR = 100;
	localparam int CONV = 4;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic main_below_thresh = 1'b0;
	logic backup_above_2v7 = 1'b1;
	logic [4:0] factory_compensation_trim_control_trim;
	logic [7:0] factory_initial_trim, factory_cold_curvature;
	logic reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [9:0] temp_code;
	logic [5:0] calc_analog;
	logic [2:0] calc_digital;
	logic on_backup, serial_enable, sram_keep_powered, osc_enable, comp_allowed;
	logic conv_busy, trim_reload, rd_seen;
	logic [5:0] analog_trim_result;
	logic [2:0] digital_trim_result;
	int seed = 76;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_reload = 0;
	int r, c;
	logic [7:0] exp_q[$];

	always #25 clock = ~clock;

	tcc_ctrl #(.CORR_CYCLES(CORR), .CONV_CYCLES(CONV)) i_tcc_ctrl (.clock(clock), .rst_n(rst_n),
		.main_below_thresh(main_below_thresh), .backup_above_2v7(backup_above_2v7),
		.factory_compensation_trim_control_trim(factory_compensation_trim_control_trim), .factory_initial_trim(factory_initial_trim),
		.factory_cold_curvature(factory_cold_curvature), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .temp_code(temp_code),
		.calc_analog(calc_analog), .calc_digital(calc_digital), .on_backup(on_backup),
		.serial_enable(serial_enable), .sram_keep_powered(sram_keep_powered), .osc_enable(osc_enable),
		.comp_allowed(comp_allowed), .conv_busy(conv_busy), .trim_reload(trim_reload),
		.analog_trim_result(analog_trim_result), .digital_trim_result(digital_trim_result));

	tcc_host i_tcc_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		cmp_count++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// an accepted read answers one cycle later; oldest note is compared
	always @(posedge clock) rd_seen <= reg_rd & ~on_backup & osc_enable & rst_n;
	always @(negedge clock) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				check(32'hDEAD, 32'h0);
			end else begin
				check(reg_rdata, exp_q.pop_front());
			end
		end
		if (trim_reload) begin
			n_reload++;
			check({analog_trim_result, digital_trim_result}, {calc_analog, calc_digital});
		end
	end

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_tcc_host.rd(a);
	endtask

	// counts conversion starts over a fixed window of cycles
	task automatic count_rises(input int n, output int rises);
		logic prev;
		prev = conv_busy;
		rises = 0;
		repeat (n) begin
			@(negedge clock);
			if (conv_busy && !prev) rises++;
			prev = conv_busy;
		end
	endtask

	// bounded wait for a given reload total
	task automatic wait_reload(input int target);
		int k;
		for (k = 0; k < 40 && n_reload < target; k++) @(negedge clock);
		if (n_reload < target) begin
			n_mismatch++;
			final_report();
		end
	endtask

	initial begin
		factory_compensation_trim_control_trim = 5'($random(seed));
		factory_initial_trim = 8'($random(seed));
		factory_cold_curvature = 8'($random(seed));
		temp_code = 10'($random(seed));
		calc_analog = 6'($random(seed));
		calc_digital = 3'($random(seed));
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		repeat (2) @(negedge clock);
		rd_chk(8'h0B, factory_initial_trim);
		rd_chk(8'h0C, factory_cold_curvature);
		rd_chk(8'h0D, {3'b000, factory_compensation_trim_control_trim});
		rd_chk(8'h20, 8'h00);
		$display("test power_up done");
		i_tcc_host.wr(8'h0B, ~factory_initial_trim);
		i_tcc_host.wr(8'h0C, ~factory_cold_curvature);
		rd_chk(8'h0B, factory_initial_trim);
		rd_chk(8'h0C, factory_cold_curvature);
		for (int m = 0; m < 4; m++) begin
			i_tcc_host.wr(8'h0D, {1'b0, 2'(m), 5'($random(seed))});
			rd_chk(8'h0D, {1'b0, 2'(m), factory_compensation_trim_control_trim});
		end
		$display("test register_access done");
		exp_q.push_back({3'b011, factory_compensation_trim_control_trim});
		i_tcc_host.enable_comp(3'b100);
		wait_reload(1);
		check(n_reload, 1);
		i_tcc_host.wr(8'h0D, 8'h80);
		i_tcc_host.idle(CONV + 6);
		check(n_reload, 1);
		temp_code = ~temp_code;
		calc_analog = 6'($random(seed));
		calc_digital = 3'($random(seed));
		i_tcc_host.wr(8'h0D, 8'h80);
		// negedges counted from the write edge: the kick conversion ends, then the timer starts the next
		c = 1;
		while (c < 2 * CORR && conv_busy) begin
			@(negedge clock);
			c++;
		end
		while (c < 2 * CORR && !conv_busy) begin
			@(negedge clock);
			c++;
		end
		check(n_reload, 2);
		check(c, CORR + 1);
		if (c >= 2 * CORR) begin
			final_report();
		end
		$display("test conversions done");
		i_tcc_host.wr(8'h0D, 8'h00);
		count_rises(3 * CORR, r);
		check(r, 0);
		$display("test sense_off done");
		i_tcc_host.wr(8'h0D, 8'hA0);
		main_below_thresh = 1'b1;
		repeat (5) @(negedge clock);
		check({on_backup, serial_enable}, 2'b10);
		check({osc_enable, sram_keep_powered, comp_allowed}, 3'b111);
		i_tcc_host.wr(8'h0D, 8'h00);
		i_tcc_host.rd(8'h0D);
		count_rises(2 * CORR + 10, r);
		check(r, 2);
		backup_above_2v7 = 1'b0;
		repeat (5) @(negedge clock);
		check(comp_allowed, 0);
		count_rises(2 * CORR + 10, r);
		check(r, 0);
		main_below_thresh = 1'b0;
		backup_above_2v7 = 1'b1;
		repeat (5) @(negedge clock);
		check(serial_enable, 1);
		rd_chk(8'h0D, {3'b101, factory_compensation_trim_control_trim});
		i_tcc_host.idle(3);
		check(exp_q.size(), 0);
		// longer strides on backup: every second and every fourth period
		for (int m = 2; m < 4; m++) begin
			main_below_thresh = 1'b0;
			repeat (5) @(negedge clock);
			i_tcc_host.wr(8'h0D, {1'b1, 2'(m), factory_compensation_trim_control_trim});
			main_below_thresh = 1'b1;
			repeat (5) @(negedge clock);
			count_rises(4 * CORR + 10, r);
			check(r, (m == 2) ? 2 : 1);
		end
		main_below_thresh = 1'b0;
		repeat (5) @(negedge clock);
		$display("test backup done");
		final_report();
	end
endmodule // tb_tcc_ctrl
